//--- hdl/dqphy_top.sv
// Double-rate memory interface: clocks, commands, write launch, read capture
`timescale 1ns/1ps

// Read-data FIFO with level output
module dqphy_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// Occupancy
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic do_push;
	logic do_pop;

	// Handshakes
	assign in_ready = (level != DEPTH[AW:0]);
	assign out_valid = (level != '0);
	assign out_data = mem[rptr];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wptr] <= in_data;
		end
	end

	// Pointers and level
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr <= '0;
			rptr <= '0;
			level <= '0;
		end else begin
			if (do_push) begin
				wptr <= wptr + 1'b1;
			end
			if (do_pop) begin
				rptr <= rptr + 1'b1;
			end
			level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule // dqphy_fifo

// Physical side toward DDR/DDR2 SDRAM or QDRII SRAM
module dqphy_top #(
	parameter int CK_DIV = dqphy_pkg::CK_DIV,
	parameter int STROBE_SHIFT = dqphy_pkg::STROBE_SHIFT,
	parameter int FIFO_DEPTH = dqphy_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire dqphy_pkg::dqphy_cfg_t cfg,
	output logic mode_bl4,
	// Request stream
	input wire logic req_valid,
	output logic req_ready,
	input wire dqphy_pkg::dqphy_req_t req,
	// Read data stream
	output logic rd_valid,
	input wire logic rd_ready,
	output dqphy_pkg::dqphy_rdata_t rd_data,
	// Memory clocks
	output logic ck_o,
	output logic ck_n_o,
	output logic c_o,
	output logic c_n_o,
	// Command and address
	output dqphy_pkg::dqphy_bus_t mem_bus,
	// Data, strobe and mask
	input wire logic [dqphy_pkg::DATA_W-1:0] dq_i,
	output logic [dqphy_pkg::DATA_W-1:0] dq_o,
	output logic dq_oe,
	output logic [dqphy_pkg::DATA_W-1:0] d_o,
	input wire logic [dqphy_pkg::NG-1:0] dqs_i,
	output logic [dqphy_pkg::NG-1:0] dqs_o,
	output logic [dqphy_pkg::NG-1:0] dqs_oe,
	output logic [dqphy_pkg::NG-1:0] dm_o,
	// Echo clock pins
	input wire logic [dqphy_pkg::NG-1:0] cq_i,
	output logic [dqphy_pkg::NG-1:0] cq_o,
	output logic [dqphy_pkg::NG-1:0] cq_oe,
	input wire logic [dqphy_pkg::NG-1:0] complement_echo_input_pin_i,
	output logic [dqphy_pkg::NG-1:0] complement_echo_input_pin_o,
	output logic [dqphy_pkg::NG-1:0] complement_echo_input_pin_oe
);
	localparam int NG = dqphy_pkg::NG;
	localparam int LW = dqphy_pkg::LANE_W;
	localparam int DW = dqphy_pkg::DATA_W;
	localparam int LVW = $clog2(FIFO_DEPTH) + 1;
	localparam logic [7:0] PH_LAST = 8'(CK_DIV - 1);
	localparam logic [7:0] PH_FALL = 8'(CK_DIV / 2);
	localparam logic [7:0] PH_TAKE = 8'(CK_DIV / 2 - 1);
	localparam logic [7:0] PH_DQ_R = 8'(CK_DIV - CK_DIV / 4 - 1); // Two clocks ahead of the strobe rise
	localparam logic [7:0] PH_DQ_F = 8'(CK_DIV / 4 - 1); // Two clocks ahead of the strobe fall
	localparam logic [7:0] PH_PRE = 8'(CK_DIV / 4 - 2);

	logic [7:0] ph;
	logic qdr;
	logic bl4;
	dqphy_pkg::dqphy_req_t cur;
	logic pend;
	logic wr_pend;
	logic wr_beat;
	logic take;
	logic [7:0] rd_exp;
	logic [LVW-1:0] level;
	logic push;
	logic [NG-1:0] grp_rdy;
	dqphy_pkg::dqphy_rdata_t pair;
	logic [DW-1:0] dq_m;
	logic [DW-1:0] dq_s;
	logic [NG-1:0] dqs_m;
	logic [NG-1:0] dqs_s;
	logic [NG-1:0] cq_m;
	logic [NG-1:0] cq_s;
	logic [NG-1:0] cqn_m;
	logic [NG-1:0] cqn_s;

	// Mode decode; DDR2 never runs burst of two
	assign qdr = (cfg.mode == dqphy_pkg::DQPHY_QDR);
	assign bl4 = cfg.bl4 || (cfg.mode == dqphy_pkg::DQPHY_DDR2);
	assign take = req_valid && req_ready;

	// Memory clock phase counter
	always_ff @(posedge clk) begin
		if (rst) begin
			ph <= dqphy_pkg::RST_PHASE;
		end else if (ph == PH_LAST) begin
			ph <= '0;
		end else begin
			ph <= ph + 8'h01;
		end
	end

	// Clock pair from double-rate style flops; output clocks parked
	always_ff @(posedge clk) begin
		if (rst) begin
			ck_o <= dqphy_pkg::RST_CK;
			ck_n_o <= ~dqphy_pkg::RST_CK;
			c_o <= 1'b0;
			c_n_o <= 1'b1;
			mode_bl4 <= 1'b1;
		end else begin
			if (ph == PH_LAST) begin
				ck_o <= 1'b1;
				ck_n_o <= 1'b0;
			end else if (ph == PH_TAKE) begin
				ck_o <= 1'b0;
				ck_n_o <= 1'b1;
			end
			c_o <= 1'b0;
			c_n_o <= 1'b1;
			mode_bl4 <= bl4;
		end
	end

	// Request acceptance, stalled while read space is short
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (ph == PH_TAKE - 8'h01) && !pend
				&& (32'(level) + 32'(rd_exp) + dqphy_pkg::FIFO_SPARE <= FIFO_DEPTH);
		end
	end

	// Held request
	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
			pend <= 1'b0;
		end else if (take) begin
			cur <= req;
			pend <= 1'b1;
		end else if (pend && (ph == ((cfg.cmd_negedge || qdr) ? PH_FALL : 8'h00))) begin
			pend <= 1'b0;
		end
	end

	// Command and address launch
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_bus <= '0;
		end else if (ph == ((cfg.cmd_negedge || qdr) ? PH_FALL : 8'h00)) begin
			// Launch point sits a half cycle off the sampling rise with cmd_negedge or QDR, at the rise otherwise
			mem_bus.rd <= pend && cur.op[0];
			mem_bus.wr <= pend && cur.op[1];
			mem_bus.addr <= (qdr && !cur.op[0]) ? cur.waddr : cur.addr;
		end else if (qdr && !bl4 && ph == 8'h00 && mem_bus.wr) begin
			mem_bus.addr <= cur.waddr;
		end
	end

	// Write beat scheduling
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_beat <= 1'b0;
		end else begin
			if (pend && cur.op[1] && ph == ((cfg.cmd_negedge || qdr) ? PH_FALL : 8'h00)) begin
				wr_pend <= 1'b1;
			end else if (ph == PH_DQ_R) begin
				wr_pend <= 1'b0;
			end
			if (ph == PH_DQ_R) begin
				wr_beat <= wr_pend;
			end
		end
	end

	// Write data at -90 degrees: rise word then fall word
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_o <= '0;
			d_o <= '0;
			dm_o <= '0;
			dq_oe <= dqphy_pkg::RST_OE;
		end else if (ph == PH_DQ_R) begin
			dq_o <= cur.wd_rise;
			d_o <= cur.wd_rise;
			dm_o <= wr_pend ? cur.wm_rise : '0;
			dq_oe <= wr_pend && !qdr;
		end else if (ph == PH_DQ_F && wr_beat) begin
			dq_o <= cur.wd_fall;
			d_o <= cur.wd_fall;
			dm_o <= cur.wm_fall;
		end
	end

	// Write strobe launched with the clock rise, zero skew
	always_ff @(posedge clk) begin
		if (rst) begin
			dqs_o <= '0;
			dqs_oe <= {NG{dqphy_pkg::RST_OE}};
		end else begin
			if (ph == PH_LAST) begin
				dqs_o <= {NG{wr_beat && !qdr}};
			end else if (ph == PH_TAKE) begin
				dqs_o <= '0;
			end
			if (ph == PH_DQ_R) begin
				dqs_oe <= {NG{wr_pend && !qdr}};
			end else if (ph == PH_PRE && wr_beat && !qdr) begin
				dqs_oe <= '1;
			end
		end
	end

	// Echo pins are inputs only
	always_ff @(posedge clk) begin
		if (rst) begin
			cq_o <= '0;
			cq_oe <= '0;
			complement_echo_input_pin_o <= '0;
			complement_echo_input_pin_oe <= '0;
		end else begin
			cq_o <= '0;
			cq_oe <= '0;
			complement_echo_input_pin_o <= '0;
			complement_echo_input_pin_oe <= '0;
		end
	end

	// Two-flop synchronisers on every incoming pin
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_m <= '0;
			dq_s <= '0;
			dqs_m <= '0;
			dqs_s <= '0;
			cq_m <= '0;
			cq_s <= '0;
			cqn_m <= '0;
			cqn_s <= '0;
		end else begin
			dq_m <= dq_i;
			dq_s <= dq_m;
			dqs_m <= dqs_i;
			dqs_s <= dqs_m;
			cq_m <= cq_i;
			cq_s <= cq_m;
			cqn_m <= complement_echo_input_pin_i;
			cqn_s <= cqn_m;
		end
	end

	// Outstanding read pairs
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_exp <= '0;
		end else begin
			rd_exp <= rd_exp + ((pend && cur.op[0] && ph == ((cfg.cmd_negedge || qdr) ? PH_FALL : 8'h00))
				? (bl4 ? 8'h02 : 8'h01) : 8'h00) - (push ? 8'h01 : 8'h00);
		end
	end

	// One independent x8 capture group per strobe, the check group included
	for (genvar g = 0; g < NG; g++) begin : grp
		logic t_prev;
		logic c_prev;
		logic [STROBE_SHIFT-1:0] t_dly;
		logic [STROBE_SHIFT-1:0] c_dly;
		logic [LW-1:0] cap_a;
		logic [LW-1:0] cap_b;
		logic [LW-1:0] cap_c;
		logic got_b;
		logic rdy;
		logic t_lvl;
		logic c_lvl;

		// Strobe selection; DDR inverts the strobe, QDR reads the complement echo pin
		assign t_lvl = qdr ? cq_s[g] : dqs_s[g];
		assign c_lvl = qdr ? cqn_s[g] : ~dqs_s[g];
		assign grp_rdy[g] = rdy;
		assign pair.rise[g*LW +: LW] = qdr ? cap_c : cap_a;
		assign pair.fall[g*LW +: LW] = cap_b;

		// Edge find and quarter-period delay line
		always_ff @(posedge clk) begin
			if (rst) begin
				t_prev <= 1'b0;
				c_prev <= 1'b0;
				t_dly <= '0;
				c_dly <= '0;
			end else begin
				t_prev <= t_lvl;
				c_prev <= c_lvl;
				t_dly <= STROBE_SHIFT'({t_dly, t_lvl && !t_prev});
				c_dly <= STROBE_SHIFT'({c_dly, c_lvl && !c_prev});
			end
		end

		// Capture: true edge loads A and C, complement edge loads B
		always_ff @(posedge clk) begin
			if (rst) begin
				cap_a <= '0;
				cap_b <= '0;
				cap_c <= '0;
				got_b <= 1'b0;
				rdy <= 1'b0;
			end else begin
				if (t_dly[STROBE_SHIFT-1]) begin
					cap_a <= dq_s[g*LW +: LW];
					cap_c <= cap_a;
				end
				if (c_dly[STROBE_SHIFT-1]) begin
					cap_b <= dq_s[g*LW +: LW];
				end
				// Ready: DDR after the fall word, QDR at the next true edge
				if (push) begin
					rdy <= 1'b0;
				end else if (!qdr && c_dly[STROBE_SHIFT-1] && rd_exp != 8'h00) begin
					rdy <= 1'b1;
				end else if (qdr && t_dly[STROBE_SHIFT-1] && got_b) begin
					rdy <= 1'b1;
				end
				if (qdr && c_dly[STROBE_SHIFT-1]) begin
					got_b <= (rd_exp != 8'h00);
				end else if (t_dly[STROBE_SHIFT-1]) begin
					got_b <= 1'b0;
				end
			end
		end
	end

	// Pair complete once every group has its words
	assign push = (&grp_rdy) && (rd_exp != 8'h00);

	// Read FIFO into the system clock domain
	dqphy_fifo #(
		.W($bits(dqphy_pkg::dqphy_rdata_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(),
		.in_data(pair),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data),
		.level(level)
	);
endmodule // dqphy_top

//--- inc/dqphy_pkg.sv
// Package: constants and carrier types of the double-rate memory interface
package dqphy_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CK_PERIOD_NS = 80;
	localparam int CK_DIV = CK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int READ_SHIFT_DEG = 90;
	localparam int STROBE_SHIFT = (CK_DIV * READ_SHIFT_DEG + 359) / 360;
	localparam int DQSS_PCT = 25;
	localparam int DQSS_MAX = (CK_DIV * DQSS_PCT) / 100;
	// Lane layout
	localparam int LANE_W = 8;
	localparam int GROUPS = 9;
	localparam int ECC_GROUPS = 1;
	localparam int NG = GROUPS + ECC_GROUPS;
	localparam int DATA_W = NG * LANE_W;
	localparam int ADDR_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_SPARE = 4;
	// Reset values
	localparam logic [7:0] RST_PHASE = 8'h00;
	localparam logic RST_CK = 1'h1;
	localparam logic RST_OE = 1'h0;

	typedef enum logic [1:0] {DQPHY_DDR, DQPHY_DDR2, DQPHY_QDR} dqphy_mode_t;
	typedef enum logic [1:0] {DQPHY_NOP, DQPHY_RD, DQPHY_WR, DQPHY_RDWR} dqphy_op_t;

	typedef struct packed {
		dqphy_mode_t mode;
		logic bl4;
		logic cmd_negedge;
	} dqphy_cfg_t;

	typedef struct packed {
		dqphy_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wd_rise;
		logic [DATA_W-1:0] wd_fall;
		logic [NG-1:0] wm_rise;
		logic [NG-1:0] wm_fall;
	} dqphy_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rise;
		logic [DATA_W-1:0] fall;
	} dqphy_rdata_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
	} dqphy_bus_t;
endpackage

//--- dv/dqphy_assertions.sv
// Checker: port properties of the memory interface
`timescale 1ns/1ps
module dqphy_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// User side
	input wire dqphy_pkg::dqphy_cfg_t cfg,
	input wire logic mode_bl4,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire dqphy_pkg::dqphy_req_t req,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire dqphy_pkg::dqphy_rdata_t rd_data,
	// Memory side
	input wire logic ck_o,
	input wire logic ck_n_o,
	input wire logic c_o,
	input wire logic c_n_o,
	input wire dqphy_pkg::dqphy_bus_t mem_bus,
	input wire logic dq_oe,
	input wire logic [dqphy_pkg::NG-1:0] dqs_o,
	input wire logic [dqphy_pkg::NG-1:0] cq_oe,
	input wire logic [dqphy_pkg::NG-1:0] complement_echo_input_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Memory clock halves of four system clocks each
	sequence ck_high_s; ck_o [*4]; endsequence
	sequence ck_low_s; !ck_o [*4]; endsequence
	// Clock outputs
	ck_period_a: assert property ($rose(ck_o) |-> ck_high_s ##1 ck_low_s)
		else $error("memory clock period wrong");
	ck_pair_a: assert property (ck_n_o == !ck_o)
		else $error("clock complement wrong");
	out_clk_idle_a: assert property (!c_o && c_n_o)
		else $error("output clock pair driven");
	echo_oe_low_a: assert property (cq_oe == '0 && complement_echo_input_pin_oe == '0)
		else $error("echo pin enabled");
	// Commands
	ready_pulse_a: assert property (req_ready |=> !req_ready [*7])
		else $error("two requests in one period");
	cmd_edge_a: assert property ($changed(mem_bus) && cfg.mode != dqphy_pkg::DQPHY_QDR
		|-> (cfg.cmd_negedge ? (!ck_o && $past(ck_o, 2)) : (ck_o && !$past(ck_o, 2))))
		else $error("command on wrong edge");
	rd_cmd_a: assert property (req_valid && req_ready && req.op == dqphy_pkg::DQPHY_RD
		|-> ##[1:8] mem_bus.rd) else $error("read not launched");
	burst_len_a: assert property (cfg.mode == dqphy_pkg::DQPHY_DDR2 |=> mode_bl4)
		else $error("burst two in second generation mode");
	// Data path
	qdr_dq_off_a: assert property (cfg.mode == dqphy_pkg::DQPHY_QDR |-> !dq_oe)
		else $error("shared data bus driven in QDR");
	dqs_window_a: assert property ($rose(dqs_o[0]) |-> (ck_o && !$past(ck_o, 3))
		or (1'b1 ##[1:2] $rose(ck_o))) else $error("strobe too far from clock");
	dq_centre_a: assert property ($rose(dq_oe) |-> ##2 $rose(dqs_o[0]))
		else $error("write data not a quarter period ahead of strobe");
	rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("read word not held");
endmodule // dqphy_checker

bind dqphy_top dqphy_checker u_dqphy_checker (.clk(clk), .rst(rst), .cfg(cfg), .mode_bl4(mode_bl4),
	.req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_ready(rd_ready),
	.rd_data(rd_data), .ck_o(ck_o), .ck_n_o(ck_n_o), .c_o(c_o), .c_n_o(c_n_o), .mem_bus(mem_bus),
	.dq_oe(dq_oe), .dqs_o(dqs_o), .cq_oe(cq_oe), .complement_echo_input_pin_oe(complement_echo_input_pin_oe));

//--- dv/dqphy_mem_model.sv
// Memory-side model: answers reads with strobe or echo edges
`timescale 1ns/1ps
module dqphy_mem_model (
	// Clock and controls
	input wire logic clk,
	input wire logic qdr,
	input int lag,
	output logic busy,
	// Memory pins
	input wire dqphy_pkg::dqphy_bus_t mem_bus,
	output logic [dqphy_pkg::DATA_W-1:0] dq_i,
	output logic [dqphy_pkg::NG-1:0] dqs_i,
	output logic [dqphy_pkg::NG-1:0] cq_i,
	output logic [dqphy_pkg::NG-1:0] cqn_i
);
	logic s = 0;
	logic [15:0] a;
	// One edge source; complement is its exact inverse, no complement strobe
	assign dqs_i = {dqphy_pkg::NG{s & !qdr}};
	assign cq_i = {dqphy_pkg::NG{s & qdr}};
	assign cqn_i = ~cq_i;
	// Read burst edge-aligned with strobe; strobe still and data spoilt after hold
	initial begin
		busy = 0;
		dq_i = '0;
		forever begin
			@(posedge clk);
			if (mem_bus.rd) begin
				busy = 1;
				a = mem_bus.addr;
				repeat (lag) @(posedge clk);
				#3 dq_i = {5{a}};
				s = 1;
				#62.5 dq_i = ~{5{a}};
				s = 0;
				#62.5 dq_i = {5{~a}};
				s = 1;
				#62.5 s = 0;
				#62.5 dq_i = ~dq_i;
				busy = 0;
			end
		end
	end
endmodule // dqphy_mem_model

//--- dv/dqphy_top_bench.sv
// Bench: reset, write launch, read capture, FIFO fill and drain
`timescale 1ns/1ps
module dqphy_top_bench;
	logic clk = 0;
	logic rst = 1;
	dqphy_pkg::dqphy_cfg_t cfg = '0;
	dqphy_pkg::dqphy_req_t req = '0;
	logic req_valid = 0;
	logic rd_ready = 0;
	logic mode_bl4, req_ready, rd_valid, ck_o, ck_n_o, c_o, c_n_o, dq_oe, busy;
	dqphy_pkg::dqphy_rdata_t rd_data;
	dqphy_pkg::dqphy_bus_t mem_bus;
	logic [79:0] dq_i, dq_o, d_o;
	logic [9:0] dqs_i, dqs_o, dqs_oe, dm_o, cq_i, cq_o, cq_oe, cqn_i, cqn_o, cqn_oe;
	int errors = 0;
	int n_compared = 0;
	int lag = 2;
	// Clock
	always #5 clk = ~clk;
	dqphy_top u_dqphy_top (.clk(clk), .rst(rst), .cfg(cfg), .mode_bl4(mode_bl4), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.ck_o(ck_o), .ck_n_o(ck_n_o), .c_o(c_o), .c_n_o(c_n_o), .mem_bus(mem_bus), .dq_i(dq_i), .dq_o(dq_o),
		.dq_oe(dq_oe), .d_o(d_o), .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dm_o(dm_o), .cq_i(cq_i),
		.cq_o(cq_o), .cq_oe(cq_oe), .complement_echo_input_pin_i(cqn_i), .complement_echo_input_pin_o(cqn_o),
		.complement_echo_input_pin_oe(cqn_oe));
	dqphy_mem_model u_dqphy_mem_model (.clk(clk), .qdr(cfg.mode == dqphy_pkg::DQPHY_QDR), .lag(lag),
		.busy(busy), .mem_bus(mem_bus), .dq_i(dq_i), .dqs_i(dqs_i), .cq_i(cq_i), .cqn_i(cqn_i));
	// Compare and count
	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Report and stop
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait for a level
	task automatic wait_for(ref logic sig, input logic val, input int lim);
		int k = 0;
		while (sig !== val) begin
			@(negedge clk);
			k++;
			if (k > lim) begin
				errors++;
				finish_test();
			end
		end
	endtask
	// Bounded wait for a data word, then compare
	task automatic expect_word(ref logic [79:0] bus, input logic [79:0] w);
		for (int i = 0; i < 20 && bus !== w; i++)
			@(negedge clk);
		check(bus, w);
	endtask
	// Reset into a mode, held 20 cycles
	task automatic do_reset(input dqphy_pkg::dqphy_mode_t m, input logic neg);
		@(negedge clk);
		rst = 1;
		cfg.mode = m;
		cfg.cmd_negedge = neg;
		repeat (20) @(negedge clk);
		check({ck_o, ck_n_o, mem_bus, rd_valid}, 2'h2 << 19);
		rst = 0;
		repeat (2) @(negedge clk);
	endtask
	// One request held until taken, or dropped after 40 cycles
	task automatic send(input dqphy_pkg::dqphy_op_t op, input logic [15:0] a, output bit ok);
		req.op = op;
		req.addr = a;
		req.waddr = ~a;
		req.wd_rise = {5{a}};
		req.wd_fall = {5{~a}};
		req.wm_rise = 10'h201;
		req.wm_fall = 10'h0FE;
		req_valid = 1;
		ok = 0;
		for (int i = 0; i < 40 && !ok; i++) begin
			ok = req_ready;
			@(negedge clk);
		end
		req_valid = 0;
	endtask
	// Masked write on the shared bus, commands on the clock fall
	task automatic t_write();
		bit ok;
		send(dqphy_pkg::DQPHY_WR, 16'h5AC3, ok);
		wait_for(dq_oe, 1'h1, 20);
		check({dq_o, dm_o, dqs_oe}, {{5{16'h5AC3}}, 10'h201, 10'h3FF});
		expect_word(dq_o, {5{16'hA53C}});
		check(dm_o, 10'h0FE);
	endtask
	// Reads until refused with the far side stalled, then drain in order
	task automatic t_fill();
		bit ok = 1;
		int cnt = 0;
		while (ok) begin
			send(dqphy_pkg::DQPHY_RD, 16'(cnt), ok);
			if (ok) begin
				wait_for(busy, 1'h1, 20);
				wait_for(busy, 1'h0, 100);
				cnt++;
			end
		end
		check(cnt, dqphy_pkg::FIFO_DEPTH - dqphy_pkg::FIFO_SPARE + 1);
		for (int i = 0; i < cnt; i++) begin
			wait_for(rd_valid, 1'h1, 10);
			check(rd_data, {{5{16'(i)}}, ~{5{16'(i)}}});
			rd_ready = 1;
			@(negedge clk);
		end
		rd_ready = 0;
		@(negedge clk);
		check(rd_valid, 1'h0);
	endtask
	// Concurrent read and write with a slow echo
	task automatic t_qdr();
		bit ok;
		send(dqphy_pkg::DQPHY_RDWR, 16'h1234, ok);
		expect_word(d_o, {5{16'h1234}});
		check(mem_bus, {2'h3, 16'h1234});
		expect_word(d_o, {5{16'hEDCB}});
		check(mem_bus.addr, 16'hEDCB);
		check(dq_oe, 1'h0);
		check({cq_o, cq_oe, cqn_o, cqn_oe}, 40'h0);
		wait_for(rd_valid, 1'h1, 200);
		check(rd_data, {{5{16'h1234}}, ~{5{16'h1234}}});
	endtask
	// Burst of four forced in DDR2: one read returns two pairs in order
	task automatic t_burst4();
		bit ok;
		send(dqphy_pkg::DQPHY_RD, 16'h00F0, ok);
		wait_for(busy, 1'h1, 20);
		wait_for(busy, 1'h0, 100);
		check(rd_data, {{5{16'h00F0}}, {5{16'hFF0F}}});
		rd_ready = 1;
		@(negedge clk);
		check(rd_data, {{5{16'hFF0F}}, {5{16'hFF0F}}});
		@(negedge clk);
		rd_ready = 0;
		check(rd_valid, 1'h0);
	endtask
	// Main sequence
	initial begin
		do_reset(dqphy_pkg::DQPHY_DDR, 1'h1);
		t_write();
		do_reset(dqphy_pkg::DQPHY_DDR, 1'h0);
		check(mode_bl4, 1'h0);
		t_fill();
		lag = 30;
		do_reset(dqphy_pkg::DQPHY_QDR, 1'h0);
		t_qdr();
		do_reset(dqphy_pkg::DQPHY_DDR2, 1'h0);
		check(mode_bl4, 1'h1);
		t_burst4();
		finish_test();
	end
endmodule // dqphy_top_bench
